/* File: hdl/arc_pkg.sv */
// constants and types of the converter result and calibration block
`default_nettype none
package arc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_A_HIGH = 8'h00;
  localparam logic [7:0] ADDR_A_LOW = 8'h04;
  localparam logic [7:0] ADDR_B_HIGH = 8'h08;
  localparam logic [7:0] ADDR_B_LOW = 8'h0C;
  localparam logic [7:0] ADDR_CFG_A = 8'h10;
  localparam logic [7:0] ADDR_CFG_B = 8'h14;
  localparam logic [7:0] ADDR_COEF_PTR = 8'h18;
  localparam logic [7:0] ADDR_COEF_DATA = 8'h1C;
  localparam logic [7:0] ADDR_MODE = 8'h20;
  // field positions
  localparam int CFG_LIN_POS = 0;
  localparam int CFG_OFF_POS = 1;
  localparam int CFG_GAIN_POS = 2;
  localparam int CFG_SRC_POS = 3;
  localparam int PTR_SEL_POS = 6;
  localparam int MODE_DIFF_POS = 0;
  // reset values
  localparam logic [2:0] CFG_REQ_RST = 3'h0;
  localparam logic CFG_SRC_RST = 1'b0;
  localparam logic [5:0] PTR_LOC_RST = 6'h17;
  localparam logic PTR_SEL_RST = 1'b1;
  localparam logic MODE_DIFF_RST = 1'b0;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [7:0] LIN_TRIM_RST = 8'h00;
  // coefficient locations
  localparam logic [5:0] LOC_LIN_FIRST = 6'h00;
  localparam logic [5:0] LOC_LIN_LAST = 6'h12;
  localparam logic [5:0] LOC_OFF_LO = 6'h13;
  localparam logic [5:0] LOC_OFF_HI = 6'h14;
  localparam logic [5:0] LOC_GAIN_LO = 6'h15;
  localparam logic [5:0] LOC_GAIN_HI = 6'h16;
  localparam logic [5:0] COEF_LOCS = 6'h17;
  localparam logic [7:0] OFF_HI_MASK = 8'h3F;
  localparam logic [7:0] GAIN_HI_MASK = 8'h1F;
  localparam logic [7:0] FULL_MASK = 8'hFF;
  // result and coefficient codes
  localparam logic [15:0] SE_FULL = 16'hFFFF;
  localparam logic [14:0] DIFF_FULL = 15'h7FFF;
  localparam logic [15:0] ZERO_CODE = 16'h0000;
  localparam logic [13:0] OFFSET_ZERO = 14'h2000;
  localparam logic [13:0] OFFSET_MAX = 14'h3FFF;
  localparam logic [12:0] GAIN_NOMINAL = 13'h1000;
  localparam logic [12:0] GAIN_MAX = 13'h1FFF;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int CAL_SETTLE_NS = 2000;
  localparam int CAL_SETTLE_CYC =
    (CAL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    KIND_LIN = 2'b00,
    KIND_OFF = 2'b01,
    KIND_GAIN = 2'b10
  } arc_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETTLE = 3'b001,
    ST_MEASURE = 3'b010,
    ST_WR_LO = 3'b011,
    ST_WR_HI = 3'b100,
    ST_DONE = 3'b101
  } arc_state_t;

  function automatic logic [7:0] coef_rst(input int loc);
    logic [7:0] v;
    v = LIN_TRIM_RST;
    if (loc == int'(LOC_OFF_LO)) v = OFFSET_ZERO[7:0];
    if (loc == int'(LOC_OFF_HI)) v = {2'h0, OFFSET_ZERO[13:8]};
    if (loc == int'(LOC_GAIN_LO)) v = GAIN_NOMINAL[7:0];
    if (loc == int'(LOC_GAIN_HI)) v = {3'h0, GAIN_NOMINAL[12:8]};
    return v;
  endfunction
endpackage
`default_nettype wire

/* File: hdl/arc_cal_engine.sv */
// calibration sequencer for one converter
`timescale 1ns/1ps
`default_nettype none
module arc_cal_engine #(
  parameter int SETTLE_CYC = arc_pkg::CAL_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [1:0] kind,
  input wire logic src_ext,
  input wire logic [15:0] conv_data,
  input wire logic conv_valid,
  output logic busy_ff,
  output logic [1:0] kind_ff,
  output logic src_ext_ff,
  output logic done,
  output logic wr_en,
  output logic [5:0] wr_loc,
  output logic [7:0] wr_byte
);
  localparam int CW = $clog2(SETTLE_CYC + 1);
  arc_pkg::arc_state_t state_ff, nxt_state;
  logic [CW-1:0] cnt_ff;
  logic [5:0] loc_ff;
  logic [13:0] coef_ff;
  logic [16:0] off_sum;
  logic [15:0] gain_err;
  logic [16:0] gain_sum;
  logic [13:0] meas_code;
  logic is_lin;

  assign is_lin = kind_ff == arc_pkg::KIND_LIN;
  // positive error at zero input needs a larger offset code
  assign off_sum = 17'(arc_pkg::OFFSET_ZERO) + 17'(conv_data);
  assign gain_err = arc_pkg::SE_FULL - conv_data;
  assign gain_sum = 17'(arc_pkg::GAIN_NOMINAL) + 17'(gain_err);
  assign meas_code = is_lin ? {6'h00, conv_data[7:0]} :
    (kind_ff == arc_pkg::KIND_OFF) ?
    ((off_sum > 17'(arc_pkg::OFFSET_MAX)) ? arc_pkg::OFFSET_MAX :
      off_sum[13:0]) :
    ((gain_sum > 17'(arc_pkg::GAIN_MAX)) ? {1'b0, arc_pkg::GAIN_MAX} :
      {1'b0, gain_sum[12:0]});

  assign done = state_ff == arc_pkg::ST_DONE;
  assign wr_en = state_ff == arc_pkg::ST_WR_LO ||
    state_ff == arc_pkg::ST_WR_HI;
  assign wr_loc = is_lin ? loc_ff :
    (kind_ff == arc_pkg::KIND_OFF) ?
    ((state_ff == arc_pkg::ST_WR_HI) ? arc_pkg::LOC_OFF_HI :
      arc_pkg::LOC_OFF_LO) :
    ((state_ff == arc_pkg::ST_WR_HI) ? arc_pkg::LOC_GAIN_HI :
      arc_pkg::LOC_GAIN_LO);
  assign wr_byte = (state_ff == arc_pkg::ST_WR_HI) ?
    ((kind_ff == arc_pkg::KIND_OFF) ?
      ({2'h0, coef_ff[13:8]} & arc_pkg::OFF_HI_MASK) :
      ({2'h0, coef_ff[13:8]} & arc_pkg::GAIN_HI_MASK)) : coef_ff[7:0];

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      arc_pkg::ST_IDLE: if (start) nxt_state = arc_pkg::ST_SETTLE;
      arc_pkg::ST_SETTLE:
        if (cnt_ff == CW'(SETTLE_CYC - 1)) nxt_state = arc_pkg::ST_MEASURE;
      arc_pkg::ST_MEASURE: if (conv_valid) nxt_state = arc_pkg::ST_WR_LO;
      arc_pkg::ST_WR_LO:
        if (!is_lin) nxt_state = arc_pkg::ST_WR_HI;
        else if (loc_ff == arc_pkg::LOC_LIN_LAST)
          nxt_state = arc_pkg::ST_DONE;
        else nxt_state = arc_pkg::ST_SETTLE;
      arc_pkg::ST_WR_HI: nxt_state = arc_pkg::ST_DONE;
      default: nxt_state = arc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff <= arc_pkg::ST_IDLE;
      busy_ff <= 1'b0;
      kind_ff <= arc_pkg::KIND_LIN;
      src_ext_ff <= 1'b0;
      cnt_ff <= '0;
      loc_ff <= arc_pkg::LOC_LIN_FIRST;
      coef_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      busy_ff <= nxt_state != arc_pkg::ST_IDLE;
      if (state_ff == arc_pkg::ST_IDLE && start)
      begin
        kind_ff <= kind;
        src_ext_ff <= src_ext;
        loc_ff <= arc_pkg::LOC_LIN_FIRST;
      end
      cnt_ff <= (state_ff == arc_pkg::ST_SETTLE) ? cnt_ff + 1'b1 : '0;
      if (state_ff == arc_pkg::ST_MEASURE && conv_valid)
        coef_ff <= meas_code;
      if (state_ff == arc_pkg::ST_WR_LO && is_lin)
        loc_ff <= loc_ff + 6'h01;
    end
  end
endmodule // arc_cal_engine
`default_nettype wire

/* File: hdl/arc_top.sv */
// converter result registers, calibration control and bus slave
`timescale 1ns/1ps
`default_nettype none
module arc_top #(
  parameter int SETTLE_CYC = arc_pkg::CAL_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [15:0] conv_a_data,
  input wire logic conv_a_valid,
  input wire logic [15:0] conv_b_data,
  input wire logic conv_b_valid,
  output logic conv_a_cal_active,
  output logic [1:0] conv_a_cal_kind,
  output logic conv_a_cal_src_ext,
  output logic [13:0] conv_a_offset_trim,
  output logic [12:0] conv_a_gain_trim,
  output logic conv_b_cal_active,
  output logic [1:0] conv_b_cal_kind,
  output logic conv_b_cal_src_ext,
  output logic [13:0] conv_b_offset_trim,
  output logic [12:0] conv_b_gain_trim
);
  // bus state
  logic hreadyout_ff;
  logic [31:0] hrdata_ff;
  logic hresp_ff;
  logic wr_pend_ff;
  logic rd_pend_ff;
  logic hit_ff;
  logic [7:0] addr_ff;
  logic addr_take;
  logic word_size;

  // shared control registers
  logic [5:0] ptr_loc_ff;
  logic ptr_sel_ff;
  logic diff_mode_ff;

  // decode
  logic wr_ptr;
  logic wr_mode;
  logic wr_coef;
  logic loc_valid;
  logic [7:0] wr_mask;
  logic [31:0] rd_mux;
  logic [7:0] coef_rd;

  // differential combination
  logic [15:0] diff_span;
  logic [14:0] diff_word;

  assign hreadyout = hreadyout_ff;
  assign hrdata = hrdata_ff;
  assign hresp = hresp_ff;

  // only whole-word transfers, single or sequential burst beats, are serviced
  assign word_size = hsize == 3'b010;
  assign addr_take = hsel && htrans[1] && hready;

  assign wr_ptr = wr_pend_ff && hit_ff && addr_ff == arc_pkg::ADDR_COEF_PTR;
  assign wr_mode = wr_pend_ff && hit_ff && addr_ff == arc_pkg::ADDR_MODE;
  assign wr_coef = wr_pend_ff && hit_ff &&
    addr_ff == arc_pkg::ADDR_COEF_DATA;
  assign loc_valid = ptr_loc_ff < arc_pkg::COEF_LOCS;
  assign wr_mask = (ptr_loc_ff == arc_pkg::LOC_OFF_HI) ?
    arc_pkg::OFF_HI_MASK :
    (ptr_loc_ff == arc_pkg::LOC_GAIN_HI) ? arc_pkg::GAIN_HI_MASK :
    arc_pkg::FULL_MASK;

  // magnitude of the a-b difference, halved to 15 bits
  assign diff_span = (conv_a_data >= conv_b_data) ?
    conv_a_data - conv_b_data : conv_b_data - conv_a_data;
  assign diff_word = diff_span[15:1];

  // per-converter result, request and coefficient logic
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_conv
      logic [15:0] res_ff;
      logic [2:0] req_ff;
      logic src_ff;
      logic [7:0] coef_ff [int'(arc_pkg::COEF_LOCS)];
      logic [15:0] own_data;
      logic own_valid;
      logic wr_cfg;
      logic [2:0] req_set;
      logic [2:0] req_clr;
      logic start;
      logic [1:0] start_kind;
      logic eng_busy;
      logic [1:0] eng_kind;
      logic eng_src;
      logic eng_done;
      logic eng_wr;
      logic [5:0] eng_loc;
      logic [7:0] eng_byte;
      logic sw_wr;
      logic [7:0] rd_byte;

      assign own_data = (gi == 0) ? conv_a_data : conv_b_data;
      assign own_valid = (gi == 0) ? conv_a_valid : conv_b_valid;
      assign wr_cfg = wr_pend_ff && hit_ff && addr_ff ==
        ((gi == 0) ? arc_pkg::ADDR_CFG_A : arc_pkg::ADDR_CFG_B);

      // software only sets; a new write wins over the finishing clear
      assign req_set = wr_cfg ? hwdata[arc_pkg::CFG_GAIN_POS:
        arc_pkg::CFG_LIN_POS] : 3'h0;
      assign req_clr = eng_done ? (3'h1 << eng_kind) : 3'h0;

      // linearity first, then offset, then gain
      assign start = !eng_busy && (req_ff != 3'h0);
      assign start_kind = req_ff[arc_pkg::CFG_LIN_POS] ? arc_pkg::KIND_LIN :
        req_ff[arc_pkg::CFG_OFF_POS] ? arc_pkg::KIND_OFF :
        arc_pkg::KIND_GAIN;

      assign sw_wr = wr_coef && loc_valid && ptr_sel_ff == 1'(gi);
      assign rd_byte = loc_valid ? coef_ff[ptr_loc_ff[4:0]] : 8'h00;

      arc_cal_engine #(
        .SETTLE_CYC(SETTLE_CYC)
      ) u_eng (
        .clk(clk),
        .resetn(resetn),
        .start(start),
        .kind(start_kind),
        .src_ext(src_ff),
        .conv_data(own_data),
        .conv_valid(own_valid),
        .busy_ff(eng_busy),
        .kind_ff(eng_kind),
        .src_ext_ff(eng_src),
        .done(eng_done),
        .wr_en(eng_wr),
        .wr_loc(eng_loc),
        .wr_byte(eng_byte)
      );

      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          req_ff <= arc_pkg::CFG_REQ_RST;
          src_ff <= arc_pkg::CFG_SRC_RST;
        end
        else
        begin
          req_ff <= req_set | (req_ff & ~req_clr);
          if (wr_cfg)
            src_ff <= hwdata[arc_pkg::CFG_SRC_POS];
        end
      end

      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          res_ff <= arc_pkg::RESULT_RST;
        else if (own_valid)
        begin
          if (gi == 0 && diff_mode_ff)
            res_ff <= {1'b0, diff_word};
          else
            res_ff <= own_data;
        end
      end

      // the sequencer owns the array while it writes
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          for (int k = 0; k < int'(arc_pkg::COEF_LOCS); k++)
            coef_ff[k] <= arc_pkg::coef_rst(k);
        end
        else if (eng_wr)
          coef_ff[eng_loc[4:0]] <= eng_byte;
        else if (sw_wr)
          coef_ff[ptr_loc_ff[4:0]] <= hwdata[7:0] & wr_mask;
      end
    end
  endgenerate

  assign coef_rd = ptr_sel_ff ? g_conv[1].rd_byte : g_conv[0].rd_byte;

  // read selection
  assign rd_mux = !hit_ff ? 32'h0000_0000 :
    (addr_ff == arc_pkg::ADDR_A_HIGH) ?
      {24'h00_0000, g_conv[0].res_ff[15:8]} :
    (addr_ff == arc_pkg::ADDR_A_LOW) ?
      {24'h00_0000, g_conv[0].res_ff[7:0]} :
    (addr_ff == arc_pkg::ADDR_B_HIGH) ?
      {24'h00_0000, g_conv[1].res_ff[15:8]} :
    (addr_ff == arc_pkg::ADDR_B_LOW) ?
      {24'h00_0000, g_conv[1].res_ff[7:0]} :
    (addr_ff == arc_pkg::ADDR_CFG_A) ?
      {28'h000_0000, g_conv[0].src_ff, g_conv[0].req_ff} :
    (addr_ff == arc_pkg::ADDR_CFG_B) ?
      {28'h000_0000, g_conv[1].src_ff, g_conv[1].req_ff} :
    (addr_ff == arc_pkg::ADDR_COEF_PTR) ?
      {25'h000_0000, ptr_sel_ff, ptr_loc_ff} :
    (addr_ff == arc_pkg::ADDR_COEF_DATA) ?
      {24'h00_0000, coef_rd} :
    (addr_ff == arc_pkg::ADDR_MODE) ?
      {31'h0000_0000, diff_mode_ff} :
    32'h0000_0000;

  // reads take one wait state so a write just before is visible
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hreadyout_ff <= 1'b1;
      hrdata_ff <= 32'h0000_0000;
      hresp_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      hit_ff <= 1'b0;
      addr_ff <= 8'h00;
    end
    else
    begin
      hresp_ff <= 1'b0;
      wr_pend_ff <= addr_take && hwrite && word_size;
      rd_pend_ff <= addr_take && !hwrite;
      hreadyout_ff <= !(addr_take && !hwrite);
      if (addr_take)
      begin
        addr_ff <= haddr[7:0];
        hit_ff <= haddr[31:8] == 24'h00_0000 && word_size;
      end
      if (rd_pend_ff)
        hrdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ptr_loc_ff <= arc_pkg::PTR_LOC_RST;
      ptr_sel_ff <= arc_pkg::PTR_SEL_RST;
      diff_mode_ff <= arc_pkg::MODE_DIFF_RST;
    end
    else
    begin
      if (wr_ptr)
      begin
        ptr_loc_ff <= hwdata[5:0];
        ptr_sel_ff <= hwdata[arc_pkg::PTR_SEL_POS];
      end
      if (wr_mode)
        diff_mode_ff <= hwdata[arc_pkg::MODE_DIFF_POS];
    end
  end

  // analog-facing outputs, all held in flip-flops
  assign conv_a_cal_active = g_conv[0].eng_busy;
  assign conv_a_cal_kind = g_conv[0].eng_kind;
  assign conv_a_cal_src_ext = g_conv[0].eng_src;
  assign conv_a_offset_trim = {g_conv[0].coef_ff[int'(arc_pkg::LOC_OFF_HI)][5:0],
    g_conv[0].coef_ff[int'(arc_pkg::LOC_OFF_LO)]};
  assign conv_a_gain_trim = {g_conv[0].coef_ff[int'(arc_pkg::LOC_GAIN_HI)][4:0],
    g_conv[0].coef_ff[int'(arc_pkg::LOC_GAIN_LO)]};
  assign conv_b_cal_active = g_conv[1].eng_busy;
  assign conv_b_cal_kind = g_conv[1].eng_kind;
  assign conv_b_cal_src_ext = g_conv[1].eng_src;
  assign conv_b_offset_trim = {g_conv[1].coef_ff[int'(arc_pkg::LOC_OFF_HI)][5:0],
    g_conv[1].coef_ff[int'(arc_pkg::LOC_OFF_LO)]};
  assign conv_b_gain_trim = {g_conv[1].coef_ff[int'(arc_pkg::LOC_GAIN_HI)][4:0],
    g_conv[1].coef_ff[int'(arc_pkg::LOC_GAIN_LO)]};
endmodule // arc_top
`default_nettype wire

/* File: tb/arc_chk.sv */
// concurrent checks on the result and calibration block ports
`timescale 1ns/1ps
`default_nettype none
module arc_chk #(
  parameter int SETTLE_CYC = 2
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic conv_a_cal_active,
  input wire logic [1:0] conv_a_cal_kind,
  input wire logic conv_a_cal_src_ext,
  input wire logic [13:0] conv_a_offset_trim,
  input wire logic conv_b_cal_active,
  input wire logic [12:0] conv_b_gain_trim
);
  logic rd_ph_ff;
  logic cfg_wr_ff;
  logic dwr_ff;
  wire take = hsel & htrans[1] & hready;
  wire nxt_rd_ph = (take & ~hwrite) | (rd_ph_ff & ~hreadyout);
  wire nxt_cfg_wr = take & hwrite & (hsize == 3'h2)
    & (haddr == {24'h0, arc_pkg::ADDR_CFG_A});
  // trims may move at the edge that ends a write data phase
  always_ff @(posedge clk or negedge resetn)
  if (!resetn)
  begin
    rd_ph_ff <= 1'b0;
    cfg_wr_ff <= 1'b0;
    dwr_ff <= 1'b0;
  end
  else
  begin
    rd_ph_ff <= nxt_rd_ph;
    cfg_wr_ff <= nxt_cfg_wr;
    dwr_ff <= take & hwrite;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  read_upper_a: assert property (rd_ph_ff && hreadyout |-> hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  cal_start_a: assert property (cfg_wr_ff && hwdata[2:0] != 3'h0
    && !conv_a_cal_active |-> ##[1:4] conv_a_cal_active)
    else $error("calibration did not start");
  cal_hold_a: assert property (conv_a_cal_active ##1 conv_a_cal_active
    |-> $stable(conv_a_cal_kind) && $stable(conv_a_cal_src_ext))
    else $error("calibration kind or source moved");
  cal_min_a: assert property ($rose(conv_a_cal_active) |-> conv_a_cal_active[*3])
    else $error("calibration too short");
  offset_still_a: assert property (!dwr_ff && !conv_a_cal_active
    |=> $stable(conv_a_offset_trim))
    else $error("offset moved without cause");
  gain_still_a: assert property (!dwr_ff && !conv_b_cal_active
    |=> $stable(conv_b_gain_trim))
    else $error("gain moved without cause");
  cover property (take && !hwrite);
  cover property ($rose(conv_a_cal_active));
  cover property ($rose(conv_b_cal_active));
endmodule // arc_chk
`default_nettype wire

/* File: tb/arc_top_tb_top.sv */
// self-checking bench for the result and calibration block
`timescale 1ns/1ps
`default_nettype none
module arc_top_tb_top;
  localparam int SETTLE_CYC = 2;
  logic clk, resetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, a_kind, b_kind;
  logic [2:0] hsize;
  logic [15:0] conv_a_data, conv_b_data;
  logic conv_a_valid, conv_b_valid, a_act, a_src, b_act, b_src;
  logic [13:0] a_off, b_off;
  logic [12:0] a_gain, b_gain;
  logic [15:0] da [3] = '{16'hFFFF, 16'h0001, 16'h1234};
  logic [15:0] db [3] = '{16'h0001, 16'hFFFF, 16'h1234};
  logic [5:0] loc [5] = '{6'h13, 6'h14, 6'h15, 6'h16, 6'h17};
  logic [7:0] wd [5] = '{8'hA5, 8'hFF, 8'h5A, 8'hFF, 8'hFF};
  logic [7:0] ex [5] = '{8'hA5, 8'h3F, 8'h5A, 8'h1F, 8'h00};
  logic [15:0] e;
  int fail_count, checks;

  arc_top #(.SETTLE_CYC(SETTLE_CYC)) u_arc_top (.clk(clk), .resetn(resetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .conv_a_data(conv_a_data), .conv_a_valid(conv_a_valid),
    .conv_b_data(conv_b_data), .conv_b_valid(conv_b_valid),
    .conv_a_cal_active(a_act), .conv_a_cal_kind(a_kind),
    .conv_a_cal_src_ext(a_src), .conv_a_offset_trim(a_off),
    .conv_a_gain_trim(a_gain), .conv_b_cal_active(b_act),
    .conv_b_cal_kind(b_kind), .conv_b_cal_src_ext(b_src),
    .conv_b_offset_trim(b_off), .conv_b_gain_trim(b_gain));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic test_done;
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask

  // every wait is bounded; a hang is counted and ends the run
  task automatic wait_rdy;
    int n;
    logic rdy;
    n = 0;
    do
    begin
      // ready is read settled, before the edge that acts on it
      @(negedge clk);
      rdy = hreadyout;
      @(posedge clk);
      n++;
    end
    while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1)
    begin
      fail_count++;
      test_done();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    @(negedge clk);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(n, x, r);
  endtask

  task automatic conv(input logic [15:0] a, input logic [15:0] b);
    @(posedge clk);
    conv_a_data <= a;
    conv_b_data <= b;
    conv_a_valid <= 1'b1;
    conv_b_valid <= 1'b1;
    @(posedge clk);
    conv_a_valid <= 1'b0;
    conv_b_valid <= 1'b0;
  endtask

  task automatic wait_act(input logic b, input logic lvl);
    int n;
    n = 0;
    while ((b ? b_act : a_act) !== lvl && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000)
    begin
      fail_count++;
      test_done();
    end
  endtask

  // cfg holds the source bit and one request bit; the sample stays valid
  task automatic cal(input logic b, input logic [3:0] cfg, input logic [15:0] d,
    input logic [31:0] x);
    logic [7:0] a;
    a = b ? arc_pkg::ADDR_CFG_B : arc_pkg::ADDR_CFG_A;
    @(posedge clk);
    conv_a_data <= d;
    conv_b_data <= d;
    conv_a_valid <= 1'b1;
    conv_b_valid <= 1'b1;
    wr(a, {28'h0, cfg});
    wait_act(b, 1'b1);
    chk("cal kind", {30'h0, cfg[2:1]}, {30'h0, b ? b_kind : a_kind});
    chk("cal source", {31'h0, cfg[3]}, {31'h0, b ? b_src : a_src});
    chk("other idle", 32'h0, {31'h0, b ? a_act : b_act});
    wait_act(b, 1'b0);
    conv_a_valid <= 1'b0;
    conv_b_valid <= 1'b0;
    rd("request clear", a, {28'h0, cfg[3], 3'h0});
    if (cfg[1])
      chk("offset", x, {18'h0, b ? b_off : a_off});
    if (cfg[2])
      chk("gain", x, {19'h0, b ? b_gain : a_gain});
  endtask

  initial
  begin
    fail_count = 0;
    checks = 0;
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    conv_a_data = 16'h0;
    conv_b_data = 16'h0;
    conv_a_valid = 1'b0;
    conv_b_valid = 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    chk("offset reset", 32'h2000, {18'h0, a_off});
    chk("gain reset", 32'h1000, {19'h0, b_gain});
    rd("pointer", arc_pkg::ADDR_COEF_PTR, 32'h57);
    conv(16'hFFFF, 16'h0000);
    rd("a high", arc_pkg::ADDR_A_HIGH, 32'hFF);
    rd("a low", arc_pkg::ADDR_A_LOW, 32'hFF);
    rd("b high", arc_pkg::ADDR_B_HIGH, 32'h00);
    wr(arc_pkg::ADDR_A_HIGH, 32'h12);
    rd("a high kept", arc_pkg::ADDR_A_HIGH, 32'hFF);
    rd("unmapped", 8'h24, 32'h0);
    wr(arc_pkg::ADDR_MODE, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      conv(da[i], db[i]);
      e = ((da[i] > db[i]) ? da[i] - db[i] : db[i] - da[i]) >> 1;
      rd("diff high", arc_pkg::ADDR_A_HIGH, {24'h0, e[15:8]});
      rd("diff low", arc_pkg::ADDR_A_LOW, {24'h0, e[7:0]});
      rd("b low", arc_pkg::ADDR_B_LOW, {24'h0, db[i][7:0]});
    end
    wr(arc_pkg::ADDR_MODE, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      wr(arc_pkg::ADDR_COEF_PTR, {26'h0, loc[i]});
      wr(arc_pkg::ADDR_COEF_DATA, {24'h0, wd[i]});
      rd("coef", arc_pkg::ADDR_COEF_DATA, {24'h0, ex[i]});
    end
    chk("offset a", 32'h3FA5, {18'h0, a_off});
    chk("gain a", 32'h1F5A, {19'h0, a_gain});
    wr(arc_pkg::ADDR_COEF_PTR, 32'h53);
    wr(arc_pkg::ADDR_COEF_DATA, 32'h11);
    chk("offset b", 32'h2011, {18'h0, b_off});
    chk("offset a kept", 32'h3FA5, {18'h0, a_off});
    cal(1'b0, 4'hA, 16'h0100, 32'h2100);
    cal(1'b0, 4'h2, 16'hFFFF, 32'h3FFF);
    // offset first on b, so its gain runs on a settled offset
    cal(1'b1, 4'h2, 16'h0000, 32'h2000);
    cal(1'b1, 4'h4, 16'hFF00, 32'h10FF);
    cal(1'b1, 4'hC, 16'h0000, 32'h1FFF);
    cal(1'b0, 4'h1, 16'h0034, 32'h0);
    wr(arc_pkg::ADDR_COEF_PTR, 32'h00);
    rd("trim first", arc_pkg::ADDR_COEF_DATA, 32'h34);
    wr(arc_pkg::ADDR_COEF_PTR, 32'h12);
    rd("trim last", arc_pkg::ADDR_COEF_DATA, 32'h34);
    test_done();
  end
endmodule // arc_top_tb_top

bind arc_top arc_chk #(.SETTLE_CYC(SETTLE_CYC)) u_arc_chk (.clk(clk),
  .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .conv_a_cal_active(conv_a_cal_active), .conv_a_cal_kind(conv_a_cal_kind),
  .conv_a_cal_src_ext(conv_a_cal_src_ext),
  .conv_a_offset_trim(conv_a_offset_trim),
  .conv_b_cal_active(conv_b_cal_active), .conv_b_gain_trim(conv_b_gain_trim));
`default_nettype wire
